// ===== rtl/flash_cmd_pkg.sv
package flash_cmd_pkg;

   // ==========================================================
   // Sizes
   localparam int ADDR_W      = 16;
   localparam int DATA_W      = 16;
   localparam int ARRAY_WORDS = 16;
   localparam int BLOCKS      = 4;
   localparam int PROT_WORDS  = 4;

   // ==========================================================
   // Command codes
   localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
   localparam logic [7:0] CMD_READ_IDENT   = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0] CMD_READ_QUERY   = 8'h98;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_SETUP_LOCK   = 8'h60;
   localparam logic [7:0] CMD_LOCK         = 8'h01;
   localparam logic [7:0] CMD_UNLOCK       = 8'hD0;
   localparam logic [7:0] CMD_LOCK_DOWN    = 8'h2F;
   localparam logic [7:0] CMD_SET_CONFIG   = 8'h03;
   localparam logic [7:0] CMD_PROT_SETUP   = 8'hC0;

   // ==========================================================
   // Read configuration word layout and reset value
   localparam int          CFG_MODE_BIT = 15;
   localparam int          CFG_LC_LSB   = 11;
   localparam int          CFG_WP_BIT   = 10;
   localparam int          CFG_BL_LSB   = 0;
   localparam logic [15:0] CFG_RESET    = 16'hBFCF;

   // ==========================================================
   // Status word layout and reset value
   localparam int         ST_READY    = 7;
   localparam int         ST_ERR_HIGH = 5;
   localparam int         ST_ERR_LOW  = 4;
   localparam logic [7:0] ST_RESET    = 8'h80;

   // ==========================================================
   // Identifier words (arbitrary values)
   localparam logic [15:0] MAKER_CODE  = 16'h00A5;
   localparam logic [15:0] PART_CODE   = 16'h005A;
   localparam logic [15:0] QUERY_WORD  = 16'h0011;

   // ==========================================================
   // Timing
   localparam int         CLK_PERIOD_NS = 4;
   localparam int         PROG_TIME_NS  = 1000;
   localparam int         PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] PROG_LOAD     = 9'(PROG_CYCLES - 1);

   // ==========================================================
   // Register offsets
   localparam logic [31:0] REG_ARRAY_INDEX = 32'h0000_0000;
   localparam logic [31:0] REG_ARRAY_DATA  = 32'h0000_0004;
   localparam logic [31:0] REG_STATUS      = 32'h0000_0008;
   localparam logic [31:0] REG_READ_CONFIG = 32'h0000_000C;
   localparam logic [31:0] REG_LOCK        = 32'h0000_0010;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {READ_ARRAY, READ_IDENT, READ_STATUS, READ_QUERY} read_state_type;
   typedef enum logic [1:0] {CMD_IDLE, CMD_LOCK_CFG, CMD_PROT} cmd_state_type;
   typedef enum logic [1:0] {BURST_IDLE, BURST_LATENCY, BURST_DATA} burst_state_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
      logic              chipEnableN;
      logic              outEnableN;
      logic              writeEnableN;
      logic              addr_valid_n;
      logic              flashClk;
   } pins_in_type;

   typedef struct packed {
      logic [DATA_W-1:0] dqOut;
      logic              dqOe;
      logic              waitOut;
   } pins_out_type;

   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } axi_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } axi_rsp_type;

endpackage

// ===== rtl/flash_cmd_read_ctrl.sv
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps

// Contract
// - Code 60h starts a lock or configuration sequence; 01h, D0h, 2Fh or 03h are its second codes.
// - Any other code after the setup sets both status error bits.
// - Code 01h after setup locks the addressed block.
// - Code D0h after setup unlocks the block unless it is locked down.
// - Code 2Fh after setup locks down the addressed block.
// - Code C0h arms a protection program; next write latches address, data and programs.
// - After configuration setup, any code but 03h, 01h, D0h or 2Fh sets both status error bits.
// - Code 03h after setup loads address lines 15..0 into the read configuration word.
// - After a configuration update, reads return array data.
// - Reset selects asynchronous page reads; burst reads need a configuration update.
// - Four read states exist; reset enters the array state.
// - Read state changes by read commands, a configuration update, a setup error or a program; host reissues array read after operations.
// - Asynchronous page reads happen only while configuration bit 15 is set.
// - Wait output stays deasserted in asynchronous page mode.
// - Asynchronous address latches on address-valid rising, else follows while it stays low.
// - Clock input is ignored during asynchronous page reads.
// - Page mode senses four words; address bits 1..0 pick the driven word.
// - Burst address latches on address-valid deassertion or next clock edge while asserted.
// - First burst word follows the latency delay, later words on following edges.
// - Non-array burst reads repeat the same word until the burst length ends.
// - Configuration bit 15: zero is burst, one is page mode, one after reset.
// - Status error bits set only by the device, cleared only by command 50h or reset.
module flash_cmd_read_ctrl (
   input  wire logic                        clk,
   input  wire logic                        resetn,
   input  wire flash_cmd_pkg::pins_in_type  pinsIn,
   output      flash_cmd_pkg::pins_out_type pinsOut,
   input  wire flash_cmd_pkg::axi_req_type  axiReq,
   output      flash_cmd_pkg::axi_rsp_type  axiRsp
);
   import flash_cmd_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      pins_in_type                      pinMeta;
      pins_in_type                      pinSync;
      logic                             prevClk;
      logic                             prevVld;
      logic                             prevWe;
      read_state_type                   readState;
      cmd_state_type                    cmdState;
      burst_state_type                  burstState;
      logic [7:0]                       statusWord;
      logic [15:0]                      readConfig;
      logic [ARRAY_WORDS-1:0][15:0]     array;
      logic [BLOCKS-1:0]                locked;
      logic [BLOCKS-1:0]                lockedDown;
      logic [PROT_WORDS-1:0][15:0]      prot;
      logic                             busy;
      logic [8:0]                       progCnt;
      logic [1:0]                       progAddr;
      logic [15:0]                      progData;
      logic [15:0]                      latchAddr;
      logic [3:0][15:0]                 pageBuf;
      logic [15:0]                      burstAddr;
      logic [2:0]                       latency;
      logic [4:0]                       beats;
      pins_out_type                     pinOut;
      logic                             bvalid;
      logic [1:0]                       bresp;
      logic                             rvalid;
      logic [1:0]                       rresp;
      logic [31:0]                      rdata;
      logic [3:0]                       arrayIndex;
   } state_type;

   state_type   s;
   state_type   next_s;
   pins_in_type host;
   logic        clkRise;
   logic        vldRise;
   logic        vldFall;
   logic        writeEvt;
   logic        readEn;
   logic        asyncMode;
   logic [1:0]  blk;
   logic        writeTake;

   // ==========================================================
   // Read data selection by read state
   function automatic logic [15:0] readWord(input state_type st, input logic [15:0] a, input logic [15:0] arrayWord);
      logic [15:0] w;
      w = 16'h0000;
      case (st.readState)
         READ_ARRAY: begin
            w = arrayWord;
         end
         READ_IDENT: begin
            case (a[3:0])
               4'h0: w = MAKER_CODE;
               4'h1: w = PART_CODE;
               4'h2: w = {15'h0000, st.locked[a[5:4]]} | {14'h0000, st.lockedDown[a[5:4]], 1'b0};
               4'h5: w = st.readConfig;
               4'h8, 4'h9, 4'hA, 4'hB: w = st.prot[a[1:0]];
               default: w = 16'h0000;
            endcase
         end
         READ_STATUS: begin
            w = {8'h00, st.statusWord};
         end
         default: begin
            w = QUERY_WORD;
         end
      endcase
      return w;
   endfunction

   // ==========================================================
   // Burst length decode
   function automatic logic [4:0] burstBeats(input logic [2:0] code);
      logic [4:0] b;
      case (code)
         3'h2: b = 5'h07;
         3'h3: b = 5'h0F;
         default: b = 5'h03;
      endcase
      return b;
   endfunction

   // ==========================================================
   // Pin events
   assign host      = s.pinSync;
   assign clkRise   = host.flashClk & ~s.prevClk;
   assign vldRise   = host.addr_valid_n & ~s.prevVld;
   assign vldFall   = ~host.addr_valid_n & s.prevVld;
   assign writeEvt  = host.writeEnableN & ~s.prevWe & ~host.chipEnableN;
   assign readEn    = ~host.chipEnableN & ~host.outEnableN & host.writeEnableN;
   assign asyncMode = s.readConfig[CFG_MODE_BIT];
   assign blk       = host.addr[3:2];
   assign writeTake = axiReq.awvalid & axiReq.wvalid & ~s.bvalid;

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.pinMeta = pinsIn;
      next_s.pinSync = s.pinMeta;
      next_s.prevClk = host.flashClk;
      next_s.prevVld = host.addr_valid_n;
      next_s.prevWe  = host.writeEnableN;

      // Protection program algorithm
      if (s.busy) begin
         if (s.progCnt == 9'h000) begin
            next_s.busy                 = 1'b0;
            next_s.prot[s.progAddr]     = s.prot[s.progAddr] & s.progData;
            next_s.statusWord[ST_READY] = 1'b1;
         end else begin
            next_s.progCnt = s.progCnt - 9'h001;
         end
      end

      // Command interpreter
      if (writeEvt) begin
         if (s.busy) begin
            if (host.dq[7:0] == CMD_READ_STATUS) begin
               next_s.readState = READ_STATUS;
            end
         end else begin
            case (s.cmdState)
               CMD_LOCK_CFG: begin
                  next_s.cmdState = CMD_IDLE;
                  case (host.dq[7:0])
                     CMD_LOCK: begin
                        next_s.locked[blk] = 1'b1;
                     end
                     CMD_UNLOCK: begin
                        if (!s.lockedDown[blk]) begin
                           next_s.locked[blk] = 1'b0;
                        end
                     end
                     CMD_LOCK_DOWN: begin
                        next_s.locked[blk]     = 1'b1;
                        next_s.lockedDown[blk] = 1'b1;
                     end
                     CMD_SET_CONFIG: begin
                        next_s.readConfig = host.addr;
                        next_s.readState  = READ_ARRAY;
                     end
                     default: begin
                        next_s.statusWord[ST_ERR_HIGH] = 1'b1;
                        next_s.statusWord[ST_ERR_LOW]  = 1'b1;
                        next_s.readState               = READ_STATUS;
                     end
                  endcase
               end
               CMD_PROT: begin
                  next_s.cmdState             = CMD_IDLE;
                  next_s.busy                 = 1'b1;
                  next_s.progCnt              = PROG_LOAD;
                  next_s.progAddr             = host.addr[1:0];
                  next_s.progData             = host.dq;
                  next_s.statusWord[ST_READY] = 1'b0;
                  next_s.readState            = READ_STATUS;
               end
               default: begin
                  case (host.dq[7:0])
                     CMD_READ_ARRAY: begin
                        next_s.readState = READ_ARRAY;
                     end
                     CMD_READ_IDENT: begin
                        next_s.readState = READ_IDENT;
                     end
                     CMD_READ_STATUS: begin
                        next_s.readState = READ_STATUS;
                     end
                     CMD_READ_QUERY: begin
                        next_s.readState = READ_QUERY;
                     end
                     CMD_CLEAR_STATUS: begin
                        next_s.statusWord[ST_ERR_HIGH] = 1'b0;
                        next_s.statusWord[ST_ERR_LOW]  = 1'b0;
                     end
                     CMD_SETUP_LOCK: begin
                        next_s.cmdState = CMD_LOCK_CFG;
                     end
                     CMD_PROT_SETUP: begin
                        next_s.cmdState = CMD_PROT;
                     end
                     default: begin
                        next_s.cmdState = CMD_IDLE;
                     end
                  endcase
               end
            endcase
         end
      end

      // Read path
      if (asyncMode) begin
         next_s.burstState = BURST_IDLE;
         if (!host.addr_valid_n) begin
            next_s.latchAddr = host.addr;
            for (int i = 0; i < 4; i++) begin
               next_s.pageBuf[i] = s.array[{host.addr[3:2], 2'(i)}];
            end
         end
         next_s.pinOut.dqOut   = readWord(s, {s.latchAddr[15:2], host.addr[1:0]}, s.pageBuf[host.addr[1:0]]);
         next_s.pinOut.waitOut = ~s.readConfig[CFG_WP_BIT];
      end else begin
         if (host.chipEnableN) begin
            next_s.burstState = BURST_IDLE;
         end else begin
            case (s.burstState)
               BURST_IDLE: begin
                  if (vldRise || (clkRise && !host.addr_valid_n)) begin
                     next_s.latchAddr  = host.addr;
                     next_s.burstAddr  = host.addr;
                     next_s.latency    = s.readConfig[CFG_LC_LSB +: 3];
                     next_s.burstState = BURST_LATENCY;
                  end
               end
               BURST_LATENCY: begin
                  if (vldFall) begin
                     next_s.burstState = BURST_IDLE;
                  end else if (clkRise) begin
                     if (s.latency <= 3'h1) begin
                        next_s.pinOut.dqOut = readWord(s, s.burstAddr, s.array[s.burstAddr[3:0]]);
                        next_s.beats        = burstBeats(s.readConfig[CFG_BL_LSB +: 3]);
                        next_s.burstState   = BURST_DATA;
                     end else begin
                        next_s.latency = s.latency - 3'h1;
                     end
                  end
               end
               BURST_DATA: begin
                  if (vldFall) begin
                     next_s.burstState = BURST_IDLE;
                  end else if (clkRise && (s.beats != 5'h00 || s.readConfig[CFG_BL_LSB +: 3] == 3'h7)) begin
                     if (s.readState == READ_ARRAY) begin
                        next_s.burstAddr    = s.burstAddr + 16'h0001;
                        next_s.pinOut.dqOut = readWord(s, s.burstAddr + 16'h0001,
                                                       s.array[4'(s.burstAddr[3:0] + 4'h1)]);
                     end else begin
                        next_s.pinOut.dqOut = readWord(s, s.burstAddr, 16'h0000);
                     end
                     next_s.beats = s.beats - 5'h01;
                  end
               end
               default: begin
                  next_s.burstState = BURST_IDLE;
               end
            endcase
         end
         next_s.pinOut.waitOut = (next_s.burstState == BURST_LATENCY) ^ ~s.readConfig[CFG_WP_BIT];
      end
      next_s.pinOut.dqOe = readEn;

      // Register bus write
      if (writeTake) begin
         next_s.bvalid = 1'b1;
         next_s.bresp  = RESP_OKAY;
         case (axiReq.awaddr)
            REG_ARRAY_INDEX: begin
               if (axiReq.wstrb[0]) begin
                  next_s.arrayIndex = axiReq.wdata[3:0];
               end
            end
            REG_ARRAY_DATA: begin
               if (axiReq.wstrb[0]) begin
                  next_s.array[s.arrayIndex][7:0] = axiReq.wdata[7:0];
               end
               if (axiReq.wstrb[1]) begin
                  next_s.array[s.arrayIndex][15:8] = axiReq.wdata[15:8];
               end
               next_s.arrayIndex = s.arrayIndex + 4'h1;
            end
            REG_STATUS, REG_READ_CONFIG, REG_LOCK: begin
               next_s.bresp = RESP_OKAY;
            end
            default: begin
               next_s.bresp = RESP_SLVERR;
            end
         endcase
      end else if (s.bvalid && axiReq.bready) begin
         next_s.bvalid = 1'b0;
      end

      // Register bus read
      if (axiReq.arvalid && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         case (axiReq.araddr)
            REG_ARRAY_INDEX: next_s.rdata = {28'h0000000, s.arrayIndex};
            REG_ARRAY_DATA:  next_s.rdata = {16'h0000, s.array[s.arrayIndex]};
            REG_STATUS:      next_s.rdata = {17'h00000, s.busy, s.burstState, s.cmdState, s.readState, s.statusWord};
            REG_READ_CONFIG: next_s.rdata = {16'h0000, s.readConfig};
            REG_LOCK:        next_s.rdata = {24'h000000, s.lockedDown, s.locked};
            default: begin
               next_s.rdata = 32'h0000_0000;
               next_s.rresp = RESP_SLVERR;
            end
         endcase
      end else if (s.rvalid && axiReq.rready) begin
         next_s.rvalid = 1'b0;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s                  <= '0;
         s.pinMeta.addr_valid_n <= 1'b1;
         s.pinSync.addr_valid_n <= 1'b1;
         s.pinMeta.writeEnableN <= 1'b1;
         s.pinSync.writeEnableN <= 1'b1;
         s.pinMeta.chipEnableN  <= 1'b1;
         s.pinSync.chipEnableN  <= 1'b1;
         s.pinMeta.outEnableN   <= 1'b1;
         s.pinSync.outEnableN   <= 1'b1;
         s.prevVld          <= 1'b1;
         s.prevWe           <= 1'b1;
         s.readState        <= READ_ARRAY;
         s.cmdState         <= CMD_IDLE;
         s.burstState       <= BURST_IDLE;
         s.statusWord       <= ST_RESET;
         s.readConfig       <= CFG_RESET;
         s.prot             <= '1;
         s.pinOut.waitOut   <= ~CFG_RESET[CFG_WP_BIT];
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs
   assign pinsOut        = s.pinOut;
   assign axiRsp.awready = writeTake;
   assign axiRsp.wready  = writeTake;
   assign axiRsp.bresp   = s.bresp;
   assign axiRsp.bvalid  = s.bvalid;
   assign axiRsp.arready = ~s.rvalid;
   assign axiRsp.rdata   = s.rdata;
   assign axiRsp.rresp   = s.rresp;
   assign axiRsp.rvalid  = s.rvalid;

endmodule // flash_cmd_read_ctrl

// ===== verif/flash_cmd_read_ctrl_checker.sv
`timescale 1ns/1ps
// ============================================================
// Port checks
module flash_cmd_read_ctrl_checker (
   input wire logic                        clk,
   input wire logic                        resetn,
   input wire flash_cmd_pkg::pins_in_type  pinsIn,
   input wire flash_cmd_pkg::pins_out_type pinsOut,
   input wire flash_cmd_pkg::axi_req_type  axiReq,
   input wire flash_cmd_pkg::axi_rsp_type  axiRsp
);
   import flash_cmd_pkg::*;
   logic touched;
   always_ff @(posedge clk) begin
      if (!resetn) touched <= 1'b0;
      else if (!pinsIn.writeEnableN || axiReq.awvalid) touched <= 1'b1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_wait_page_idle: assert property (!touched |-> !pinsOut.waitOut)
      else $error("wait set in page mode");
   a_array_at_reset: assert property (!touched |-> pinsOut.dqOut == 16'h0000)
      else $error("read data not from array");
   a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !pinsOut.dqOe && !axiRsp.bvalid)
      else $error("outputs active after reset");
   a_ce_high_idle: assert property (pinsIn.chipEnableN [*4] |=> !pinsOut.dqOe)
      else $error("data driven while deselected");
   a_we_low_idle: assert property (!pinsIn.writeEnableN [*4] |=> !pinsOut.dqOe)
      else $error("data driven during write");
   a_write_answer: assert property (axiReq.awvalid && axiReq.wvalid && axiRsp.awready |=> axiRsp.bvalid)
      else $error("write not answered");
   a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
      else $error("read not answered");
   a_resp_once: assert property (axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid)
      else $error("write answer repeated");
   c_page_out: cover property (pinsOut.dqOe);
   c_write_done: cover property (axiRsp.bvalid && axiReq.bready);
   c_unmapped: cover property (axiRsp.rvalid && axiRsp.rresp == RESP_SLVERR);
endmodule // flash_cmd_read_ctrl_checker

bind flash_cmd_read_ctrl flash_cmd_read_ctrl_checker u_chk (.clk(clk), .resetn(resetn), .pinsIn(pinsIn),
   .pinsOut(pinsOut), .axiReq(axiReq), .axiRsp(axiRsp));

// ===== verif/flash_host_model.sv
`timescale 1ns/1ps
// ============================================================
// Host side of the flash pins
module flash_host_model (
   input  wire logic                        clk,
   input  wire flash_cmd_pkg::pins_out_type pinsOut,
   output      flash_cmd_pkg::pins_in_type  pins
);
   import flash_cmd_pkg::*;
   initial pins = '{addr: 16'h0000, dq: 16'h0000, default: 1'b1};
   task automatic cmd(input logic [15:0] a, input logic [7:0] c);
      pins.addr <= a;
      pins.dq <= {8'h00, c};
      pins.chipEnableN <= 1'b0;
      pins.writeEnableN <= 1'b0;
      repeat (4) @(posedge clk);
      pins.writeEnableN <= 1'b1;
      repeat (4) @(posedge clk);
      pins.chipEnableN <= 1'b1;
      pins.dq <= ~pins.dq;
      repeat (4) @(posedge clk);
   endtask
   task automatic page_read(input logic [15:0] a, output logic [63:0] d);
      pins.addr <= a;
      pins.chipEnableN <= 1'b0;
      pins.outEnableN <= 1'b0;
      pins.addr_valid_n <= 1'b0;
      repeat (4) @(posedge clk);
      pins.addr_valid_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         pins.addr[1:0] <= 2'(i);
         repeat (4) begin
            repeat (2) @(posedge clk);
            pins.flashClk <= ~pins.flashClk;
         end
         #1 d[16*i +: 16] = pinsOut.dqOut;
         @(posedge clk);
      end
      pins.chipEnableN <= 1'b1;
      pins.outEnableN <= 1'b1;
      pins.addr <= ~pins.addr;
      @(posedge clk);
   endtask
   task automatic burst_read(input logic [15:0] a, output logic [63:0] d);
      pins.addr <= a;
      pins.chipEnableN <= 1'b0;
      pins.outEnableN <= 1'b0;
      pins.addr_valid_n <= 1'b0;
      repeat (4) @(posedge clk);
      pins.addr_valid_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         repeat (4) @(posedge clk);
         pins.flashClk <= 1'b0;
         repeat (4) @(posedge clk);
         pins.flashClk <= 1'b1;
         repeat (4) @(posedge clk);
         #1 if (i > 0) d[16*(i-1) +: 16] = pinsOut.dqOut;
      end
      @(posedge clk);
      pins.chipEnableN <= 1'b1;
      pins.outEnableN <= 1'b1;
      @(posedge clk);
   endtask
endmodule // flash_host_model

// ===== verif/flash_cmd_read_ctrl_test.sv
`timescale 1ns/1ps
// ============================================================
// Bench
module flash_cmd_read_ctrl_test;
   import flash_cmd_pkg::*;
   logic         clk = 1'b0;
   logic         resetn = 1'b0;
   pins_in_type  pinsIn;
   pins_out_type pinsOut;
   axi_req_type  axiReq = '{bready: 1'b1, rready: 1'b1, wstrb: 4'hF, default: '0};
   axi_rsp_type  axiRsp;
   int           error_cnt = 0;
   int           checks = 0;
   int           cycles = 0;
   logic [31:0]  rd;
   logic [1:0]   rsp;
   logic [63:0]  page;
   always #2 clk = ~clk;
   flash_cmd_read_ctrl u_dut (.clk(clk), .resetn(resetn), .pinsIn(pinsIn), .pinsOut(pinsOut), .axiReq(axiReq),
      .axiRsp(axiRsp));
   flash_host_model u_host (.clk(clk), .pinsOut(pinsOut), .pins(pinsIn));
   task automatic tally_and_finish();
      $display("Checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      axiReq.awaddr <= a;
      axiReq.wdata <= d;
      axiReq.awvalid <= 1'b1;
      axiReq.wvalid <= 1'b1;
      do @(posedge clk); while (!axiRsp.awready);
      axiReq.awvalid <= 1'b0;
      axiReq.wvalid <= 1'b0;
      do @(posedge clk); while (!axiRsp.bvalid);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
      axiReq.araddr <= a;
      axiReq.arvalid <= 1'b1;
      do @(posedge clk); while (!axiRsp.arready);
      axiReq.arvalid <= 1'b0;
      do @(posedge clk); while (!axiRsp.rvalid);
      rsp = axiRsp.rresp;
      check($sformatf("reg %h", a), exp, axiRsp.rdata & m);
   endtask
   task automatic lock_op(input logic [15:0] a, input logic [7:0] c);
      u_host.cmd(a, CMD_SETUP_LOCK);
      u_host.cmd(a, c);
   endtask
   task automatic t_reset();
      rd_chk(REG_READ_CONFIG, 32'h0000FFFF, {16'h0000, CFG_RESET});
      rd_chk(REG_STATUS, 32'h000003FF, 32'h00000080);
      rd_chk(32'h00000040, 32'h00000000, 32'h00000000);
      check("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rsp});
   endtask
   task automatic t_lock();
      lock_op(16'h0004, CMD_LOCK);
      lock_op(16'h0008, CMD_LOCK);
      rd_chk(REG_LOCK, 32'h000000FF, 32'h00000006);
      lock_op(16'h0008, CMD_LOCK_DOWN);
      lock_op(16'h0008, CMD_UNLOCK);
      lock_op(16'h0004, CMD_UNLOCK);
      rd_chk(REG_LOCK, 32'h00000046, 32'h00000044);
   endtask
   task automatic t_status();
      lock_op(16'h0000, CMD_READ_ARRAY);
      rd_chk(REG_STATUS, 32'h000003FF, 32'h000002B0);
      u_host.cmd(16'h0000, CMD_READ_ARRAY);
      rd_chk(REG_STATUS, 32'h000003FF, 32'h000000B0);
      u_host.cmd(16'h0000, CMD_CLEAR_STATUS);
      rd_chk(REG_STATUS, 32'h000000FF, 32'h00000080);
   endtask
   task automatic t_page();
      axi_wr(REG_ARRAY_INDEX, 32'h00000004);
      for (int i = 0; i < 4; i++)
         axi_wr(REG_ARRAY_DATA, 32'h00001230 + 32'(i));
      lock_op(16'hA5C3, CMD_SET_CONFIG);
      rd_chk(REG_READ_CONFIG, 32'h0000FFFF, 32'h0000A5C3);
      rd_chk(REG_STATUS, 32'h00000300, 32'h00000000);
      u_host.page_read(16'h0004, page);
      check("page low", 32'h12311230, page[31:0]);
      check("page high", 32'h12331232, page[63:32]);
      check("wait", 32'h00000000, {31'h0, pinsOut.waitOut});
   endtask
   task automatic t_ident();
      u_host.cmd(16'h0000, CMD_READ_IDENT);
      u_host.page_read(16'h0000, page);
      check("ident", {PART_CODE, MAKER_CODE}, page[31:0]);
   endtask
   task automatic t_prot();
      u_host.cmd(16'h0001, CMD_PROT_SETUP);
      u_host.cmd(16'h0001, 8'hA5);
      rd_chk(REG_STATUS, 32'h00004080, 32'h00004000);
      repeat (PROG_CYCLES) @(posedge clk);
      rd_chk(REG_STATUS, 32'h00004080, 32'h00000080);
      u_host.cmd(16'h0000, CMD_READ_IDENT);
      u_host.page_read(16'h0008, page);
      check("prot", 32'h00A5FFFF, page[31:0]);
   endtask
   task automatic t_burst();
      lock_op(16'h1401, CMD_SET_CONFIG);
      u_host.burst_read(16'h0004, page);
      check("burst low", 32'h12311230, page[31:0]);
      check("burst high", 32'h12331232, page[63:32]);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_lock();
      t_status();
      t_page();
      t_ident();
      t_prot();
      t_burst();
      tally_and_finish();
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
endmodule // flash_cmd_read_ctrl_test
